/* File: sfsp_pkg.sv */
// Operation
// - write_in_progress reads 1 while program, erase or status write runs.
// - write_latch_flag mirrors the latch; clear latch refuses status write, program, erase.
// - protect_range_bits pick the region shielded from program, sector and block erase.
// - protect_range_bits accept new values only outside the hardware-protected state.
// - Full erase runs only with low three range bits and protect_invert zero.
// - Lock mode 00 allows status writes whenever the latch is set, any pin level.
// - Lock mode 01 blocks status writes while the protect pin is low.
// - Lock mode 10 refuses status writes until power cycle, which returns mode 00.
// - Lock mode 11 refuses every later status write permanently; here rst_b_i returns it to mode 00, as for mode 10.
// - quad_io_enable at 1 turns the protect and pause pins into data lines.
// - security_lock defaults 0, once set never clears, making security registers read-only; here rst_b_i clears it to 0.
// - protect_invert combines with protect_range_bits to choose the protected region.
// - high_perf_flag reads 1 while in high performance mode, else 0.
// - suspend_flag is read-only, set by suspend 75H, cleared by resume 7AH or power cycle.
// - Bits move MSB first, sampled on rising serial clock edges after select falls.
// - Every command opens with an 8-bit opcode, then address and data bytes as needed.
// - Reads shift data after the command; host may stop after any bit.
// - Write-type commands execute only if select rises on a multiple of eight clocks.
// - Program cut mid-byte does nothing and leaves write_latch_flag set.
// - Latch sets on write enable; clears on power-up, disable, status write, program, erase.
// - Protect pin low under hardware protection freezes range bits and lock mode.
package sfsp_pkg;
    // ==========================================================
    // Status word layout
    localparam int WIP_POS = 0;
    localparam int WEL_POS = 1;
    localparam int BP_POS = 2;
    localparam int LOCK_LO_POS = 7;
    localparam int LOCK_HI_POS = 8;
    localparam int QE_POS = 9;
    localparam int LB_POS = 10;
    localparam int HPF_POS = 13;
    localparam int CMP_POS = 14;
    localparam int SUS_POS = 15;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [1:0] LOCK_SOFT = 2'h0;
    localparam logic [1:0] LOCK_PIN = 2'h1;
    // ==========================================================
    // Opcodes
    localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] OPC_WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] OPC_RD_LO = 8'h05;
    localparam logic [7:0] OPC_RD_HI = 8'h35;
    localparam logic [7:0] OPC_STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] OPC_PROG = 8'h02;
    localparam logic [7:0] OPC_SECT = 8'h20;
    localparam logic [7:0] OPC_BLK32 = 8'h52;
    localparam logic [7:0] OPC_BLK64 = 8'hD8;
    localparam logic [7:0] OPC_CHIP_A = 8'h60;
    localparam logic [7:0] OPC_CHIP_B = 8'hC7;
    localparam logic [7:0] OPC_SUSP = 8'h75;
    localparam logic [7:0] OPC_RESUME = 8'h7A;
    localparam logic [7:0] OPC_DPD = 8'hB9;
    localparam logic [7:0] OPC_WAKE = 8'hAB;
    localparam logic [7:0] OPC_HPM = 8'hA3;
    // ==========================================================
    // Array operation kinds shown on the operation port
    localparam logic [2:0] KIND_PROG = 3'h1;
    localparam logic [2:0] KIND_SECT = 3'h2;
    localparam logic [2:0] KIND_BLK32 = 3'h3;
    localparam logic [2:0] KIND_BLK64 = 3'h4;
    localparam logic [2:0] KIND_CHIP = 3'h5;
    // ==========================================================
    // Busy times in microseconds and derived cycle counts at 25 MHz
    localparam int CLK_MHZ = 25;
    localparam int PROG_TIME_US = 400;
    localparam int ERASE_TIME_US = 2000;
    localparam int SRW_TIME_US = 200;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
    localparam int SRW_CYCLES = SRW_TIME_US * CLK_MHZ;
    localparam int BIT_CNT_W = 12;
    localparam int BUSY_CNT_W = 24;
endpackage

/* File: sfsp_core.sv */
`timescale 1ns/1ps
`default_nettype none
module sfsp_core #(
    parameter int PROG_CYCLES = sfsp_pkg::PROG_CYCLES,
    parameter int ERASE_CYCLES = sfsp_pkg::ERASE_CYCLES,
    parameter int SRW_CYCLES = sfsp_pkg::SRW_CYCLES,
    parameter int BUF_W = 8,
    parameter int BUF_DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic si_i,
    input wire logic wp_b_i,
    output logic so_o,
    output logic so_oe_o,
    output logic [15:0] status_word_o,
    output logic op_start_o,
    output logic [2:0] op_kind_o,
    output logic [23:0] op_addr_o,
    output logic [7:0] op_data_o,
    output logic quad_io_enable_o,
    output logic security_lock_o
);
    initial begin
        if (PROG_CYCLES < 1 || ERASE_CYCLES < 1 || SRW_CYCLES < 1 ||
            PROG_CYCLES >= 2 ** sfsp_pkg::BUSY_CNT_W || ERASE_CYCLES >= 2 ** sfsp_pkg::BUSY_CNT_W ||
            SRW_CYCLES >= 2 ** sfsp_pkg::BUSY_CNT_W || BUF_W != 8 || BUF_DEPTH != 2) begin
            $error("sfsp_core: parameter out of range");
        end
    end

    typedef enum logic [1:0] {ENG_IDLE, ENG_BUSY, ENG_SUSP} sfsp_eng_t;

    // ==========================================================
    // Pin synchronisers and edge detection
    logic [1:0] sclk_s, cs_s, si_s, wp_s;
    logic sclk_d, cs_d;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_s <= 2'h0;
            cs_s <= 2'h3;
            si_s <= 2'h0;
            wp_s <= 2'h3;
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
        end else if (ce_i) begin
            sclk_s <= {sclk_s[0], sclk_i};
            cs_s <= {cs_s[0], cs_b_i};
            si_s <= {si_s[0], si_i};
            wp_s <= {wp_s[0], wp_b_i};
            sclk_d <= sclk_s[1];
            cs_d <= cs_s[1];
        end
    end
    wire selected = ~cs_s[1];
    wire sclk_rise = sclk_s[1] & ~sclk_d & selected;
    wire sclk_fall = ~sclk_s[1] & sclk_d & selected;
    wire cs_rise = cs_s[1] & ~cs_d;

    // ==========================================================
    // Command framing
    logic [sfsp_pkg::BIT_CNT_W-1:0] bit_cnt;
    logic [7:0] shift_in, opcode, data_lo, data_hi, first_data;
    logic [23:0] addr;
    wire [7:0] new_byte = {shift_in[6:0], si_s[1]};
    wire [8:0] byte_idx = bit_cnt[11:3];
    wire byte_done = sclk_rise & (bit_cnt[2:0] == 3'h7);
    wire aligned = (bit_cnt[2:0] == 3'h0);
    wire [8:0] nbytes = bit_cnt[11:3];
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_cnt <= '0;
            shift_in <= 8'h00;
            opcode <= 8'h00;
            addr <= 24'h000000;
            data_lo <= 8'h00;
            data_hi <= 8'h00;
            first_data <= 8'h00;
        end else if (ce_i) begin
            // Clearing while deselected stops a stale count from reopening a read at the next select.
            if (!selected) begin
                bit_cnt <= '0;
            end else if (sclk_rise && bit_cnt != '1) begin
                bit_cnt <= bit_cnt + 1'b1;
                shift_in <= new_byte;
            end
            if (byte_done && byte_idx == 9'h000) begin
                opcode <= new_byte;
            end
            if (byte_done && byte_idx >= 9'h001 && byte_idx <= 9'h003) begin
                addr <= {addr[15:0], new_byte};
            end
            if (byte_done && byte_idx == 9'h001) begin
                data_lo <= new_byte;
            end
            if (byte_done && byte_idx == 9'h002) begin
                data_hi <= new_byte;
            end
            if (byte_done && byte_idx == 9'h004) begin
                first_data <= new_byte;
            end
        end
    end

    // ==========================================================
    // Status word and protection decode
    logic write_latch_flag, qe, lb, cmp, high_perf_flag, sus, dpd;
    logic [4:0] bp;
    logic [1:0] lock;
    sfsp_eng_t eng_state;
    logic [sfsp_pkg::BUSY_CNT_W-1:0] busy_cnt;
    logic busy_is_array;
    wire write_in_progress = (eng_state == ENG_BUSY);
    wire [15:0] status_word = {sus, cmp, high_perf_flag, 2'h0, lb, qe, lock, bp, write_latch_flag, write_in_progress};
    wire wp_eff = qe | wp_s[1];
    wire hw_protect = (lock == sfsp_pkg::LOCK_PIN) & ~wp_eff;
    wire sr_write_ok = write_latch_flag & ((lock == sfsp_pkg::LOCK_SOFT) | ((lock == sfsp_pkg::LOCK_PIN) & wp_eff));

    // Returns 1 when the 4 KB unit lies in the protected region.
    function automatic logic unit_protected(input logic [7:0] unit, input logic [4:0] b, input logic inv);
        logic [8:0] n;
        logic hit;
        n = 9'h000;
        if (b[2:0] == 3'h0) begin
            n = 9'h000;
        end else if ((b[2] & b[1]) | (b[2] & b[0] & ~b[4])) begin
            n = 9'h100;
        end else if (!b[4]) begin
            n = 9'(9'h010 << (b[2:0] - 3'h1));
        end else if (b[2]) begin
            n = 9'h008;
        end else begin
            n = 9'(9'h001 << (b[1:0] - 2'h1));
        end
        hit = b[3] ? ({1'b0, unit} < n) : ({1'b0, unit} >= 9'h100 - n);
        return hit ^ inv;
    endfunction
    wire addr_prot = unit_protected(addr[19:12], bp, cmp);

    // ==========================================================
    // Command execution on the rising edge of chip select
    wire idle = (eng_state == ENG_IDLE) & ~dpd;
    wire go = cs_rise & aligned & (nbytes != 9'h000);
    wire op_erase = (opcode == sfsp_pkg::OPC_SECT) | (opcode == sfsp_pkg::OPC_BLK32) |
                    (opcode == sfsp_pkg::OPC_BLK64);
    wire op_chip = (opcode == sfsp_pkg::OPC_CHIP_A) | (opcode == sfsp_pkg::OPC_CHIP_B);
    wire do_write_enable_cmd = go & idle & (opcode == sfsp_pkg::OPC_WRITE_ENABLE_CMD) & (nbytes == 9'h001);
    wire do_write_disable_cmd = go & idle & (opcode == sfsp_pkg::OPC_WRITE_DISABLE_CMD) & (nbytes == 9'h001);
    wire do_srw = go & idle & (opcode == sfsp_pkg::OPC_STATUS_WRITE_CMD) & (nbytes == 9'h002 || nbytes == 9'h003) &
                  sr_write_ok;
    wire do_prog = go & idle & write_latch_flag & (opcode == sfsp_pkg::OPC_PROG) & (nbytes >= 9'h005) & ~addr_prot;
    wire do_erase = go & idle & write_latch_flag & op_erase & (nbytes == 9'h004) & ~addr_prot;
    wire do_chip = go & idle & write_latch_flag & op_chip & (nbytes == 9'h001) & (bp[2:0] == 3'h0) & ~cmp;
    wire do_dpd = go & idle & (opcode == sfsp_pkg::OPC_DPD) & (nbytes == 9'h001);
    wire do_hpm = go & idle & (opcode == sfsp_pkg::OPC_HPM) & (nbytes == 9'h004);
    wire do_wake = cs_rise & (opcode == sfsp_pkg::OPC_WAKE) & (nbytes != 9'h000);
    wire do_susp = cs_rise & ~dpd & (opcode == sfsp_pkg::OPC_SUSP) & (nbytes != 9'h000) & write_in_progress & busy_is_array;
    wire do_resume = cs_rise & ~dpd & (opcode == sfsp_pkg::OPC_RESUME) & (nbytes != 9'h000) &
                     (eng_state == ENG_SUSP);
    wire array_start = do_prog | do_erase | do_chip;
    wire [2:0] next_kind = op_chip ? sfsp_pkg::KIND_CHIP :
                           (opcode == sfsp_pkg::OPC_SECT) ? sfsp_pkg::KIND_SECT :
                           (opcode == sfsp_pkg::OPC_BLK32) ? sfsp_pkg::KIND_BLK32 :
                           (opcode == sfsp_pkg::OPC_BLK64) ? sfsp_pkg::KIND_BLK64 : sfsp_pkg::KIND_PROG;
    wire [sfsp_pkg::BUSY_CNT_W-1:0] next_busy =
        do_prog ? sfsp_pkg::BUSY_CNT_W'(PROG_CYCLES) :
        do_srw ? sfsp_pkg::BUSY_CNT_W'(SRW_CYCLES) : sfsp_pkg::BUSY_CNT_W'(ERASE_CYCLES);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            write_latch_flag <= sfsp_pkg::STATUS_RESET[sfsp_pkg::WEL_POS];
            bp <= sfsp_pkg::STATUS_RESET[sfsp_pkg::BP_POS +: 5];
            lock <= sfsp_pkg::STATUS_RESET[sfsp_pkg::LOCK_HI_POS:sfsp_pkg::LOCK_LO_POS];
            qe <= sfsp_pkg::STATUS_RESET[sfsp_pkg::QE_POS];
            lb <= sfsp_pkg::STATUS_RESET[sfsp_pkg::LB_POS];
            high_perf_flag <= sfsp_pkg::STATUS_RESET[sfsp_pkg::HPF_POS];
            cmp <= sfsp_pkg::STATUS_RESET[sfsp_pkg::CMP_POS];
            sus <= sfsp_pkg::STATUS_RESET[sfsp_pkg::SUS_POS];
            dpd <= 1'b0;
        end else if (ce_i) begin
            if (do_write_enable_cmd) begin
                write_latch_flag <= 1'b1;
            end else if (do_write_disable_cmd || do_srw || array_start) begin
                write_latch_flag <= 1'b0;
            end
            if (do_srw) begin
                bp <= data_lo[6:2];
                lock[0] <= data_lo[7];
            end
            if (do_srw && nbytes == 9'h003) begin
                lock[1] <= data_hi[0];
                qe <= data_hi[1];
                lb <= lb | data_hi[2];
                cmp <= data_hi[6];
            end
            if (do_hpm) begin
                high_perf_flag <= 1'b1;
            end else if (do_wake) begin
                high_perf_flag <= 1'b0;
            end
            if (do_susp) begin
                sus <= 1'b1;
            end else if (do_resume) begin
                sus <= 1'b0;
            end
            if (do_dpd) begin
                dpd <= 1'b1;
            end else if (do_wake) begin
                dpd <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Busy engine behind write_in_progress
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            eng_state <= ENG_IDLE;
            busy_cnt <= '0;
            busy_is_array <= 1'b0;
        end else if (ce_i) begin
            case (eng_state)
                ENG_IDLE: begin
                    if (array_start || do_srw) begin
                        eng_state <= ENG_BUSY;
                        busy_cnt <= next_busy;
                        busy_is_array <= array_start;
                    end
                end
                ENG_BUSY: begin
                    if (do_susp) begin
                        eng_state <= ENG_SUSP;
                    end else if (busy_cnt <= 1) begin
                        eng_state <= ENG_IDLE;
                        busy_cnt <= '0;
                    end else begin
                        busy_cnt <= busy_cnt - 1'b1;
                    end
                end
                ENG_SUSP: begin
                    if (do_resume) begin
                        eng_state <= ENG_BUSY;
                    end
                end
                default: begin
                    eng_state <= ENG_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Two-entry buffer between the status source and the output shifter
    logic [BUF_W-1:0] buf_mem [BUF_DEPTH];
    logic buf_wr, buf_rd;
    logic [1:0] buf_cnt;
    logic [2:0] out_bits;
    logic [7:0] out_sh;
    wire reading = selected & (nbytes != 9'h000) &
                   ((opcode == sfsp_pkg::OPC_RD_LO) | (opcode == sfsp_pkg::OPC_RD_HI));
    wire buf_in_ready = (buf_cnt != 2'h2);
    wire buf_in_valid = reading;
    wire buf_out_valid = (buf_cnt != 2'h0);
    wire buf_out_ready = sclk_fall & reading & (out_bits == 3'h0);
    wire push = buf_in_valid & buf_in_ready;
    wire pop = buf_out_valid & buf_out_ready;
    wire [7:0] src_byte = (opcode == sfsp_pkg::OPC_RD_HI) ? status_word[15:8] : status_word[7:0];
    wire [7:0] buf_head = buf_mem[buf_rd];
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            buf_mem <= '{default: '0};
            buf_wr <= 1'b0;
            buf_rd <= 1'b0;
            buf_cnt <= 2'h0;
        end else if (ce_i) begin
            if (!selected) begin
                buf_wr <= 1'b0;
                buf_rd <= 1'b0;
                buf_cnt <= 2'h0;
            end else begin
                if (push) begin
                    buf_mem[buf_wr] <= src_byte;
                    buf_wr <= ~buf_wr;
                end
                if (pop) begin
                    buf_rd <= ~buf_rd;
                end
                buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
            end
        end
    end

    // ==========================================================
    // Output shifter and registered outputs
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_bits <= 3'h0;
            out_sh <= 8'h00;
            so_o <= 1'b0;
            so_oe_o <= 1'b0;
            status_word_o <= sfsp_pkg::STATUS_RESET;
            op_start_o <= 1'b0;
            op_kind_o <= 3'h0;
            op_addr_o <= 24'h000000;
            op_data_o <= 8'h00;
            quad_io_enable_o <= 1'b0;
            security_lock_o <= 1'b0;
        end else if (ce_i) begin
            if (!selected) begin
                out_bits <= 3'h0;
            end else if (pop) begin
                so_o <= buf_head[7];
                out_sh <= {buf_head[6:0], 1'b0};
                out_bits <= 3'h7;
            end else if (sclk_fall && reading && out_bits != 3'h0) begin
                so_o <= out_sh[7];
                out_sh <= {out_sh[6:0], 1'b0};
                out_bits <= out_bits - 3'h1;
            end
            so_oe_o <= reading;
            status_word_o <= status_word;
            op_start_o <= array_start;
            if (array_start) begin
                op_kind_o <= next_kind;
                op_addr_o <= addr;
                op_data_o <= first_data;
            end
            quad_io_enable_o <= qe;
            security_lock_o <= lb;
        end
    end

    // ==========================================================
    // Checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_wip_on_start: assert property (ce_i && (do_prog || do_srw) |=> write_in_progress ##1 status_word_o[0]) else $error("busy flag not raised");
    a_latch_gates_write: assert property ((do_srw || array_start) |-> write_latch_flag) else $error("write without latch");
    a_range_frozen: assert property (hw_protect |=> $stable(bp) && $stable(lock)) else $error("range changed under pin lock");
    a_range_pin_lock: assert property (hw_protect |-> !do_srw) else $error("range write accepted while locked");
    a_full_erase_guard: assert property (do_chip |-> bp[2:0] == 3'h0 && !cmp) else $error("full erase with protection set");
    a_soft_lock_open: assert property (go && idle && write_latch_flag && lock == 2'h0 && opcode == sfsp_pkg::OPC_STATUS_WRITE_CMD &&
        nbytes == 9'h002 |-> do_srw) else $error("soft mode write refused");
    a_pin_lock_block: assert property (do_srw |-> !(lock == 2'h1 && !wp_eff)) else $error("pin mode write accepted");
    a_hard_lock: assert property (lock[1] |-> !do_srw) else $error("write accepted under hard lock");
    a_otp_lock: assert property (lock == 2'h3 && ce_i |=> lock == 2'h3 ##1 !do_srw) else $error("one-time lock broken");
    a_sec_sticky: assert property (lb |=> lb) else $error("security lock cleared");
    a_suspend_flag: assert property (ce_i && do_susp |=> sus && !write_in_progress ##1 status_word_o[15]) else $error("suspend not shown");
    a_byte_boundary: assert property ((do_write_enable_cmd || do_write_disable_cmd || do_srw || array_start || do_dpd) |-> aligned)
        else $error("write command off byte boundary");
    a_partial_prog: assert property (ce_i && cs_rise && opcode == sfsp_pkg::OPC_PROG && !aligned && write_latch_flag |=> write_latch_flag && !op_start_o)
        else $error("partial program acted");
endmodule
`default_nettype wire

/* File: sfsp_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host controller model
module sfsp_host (
    input wire logic clk_i,
    input wire logic so_i,
    output logic sclk_o,
    output logic cs_b_o,
    output logic si_o
);
    initial begin
        sclk_o = 1'b0;
        cs_b_o = 1'b1;
        si_o = 1'b0;
    end
    // Sends the low n bits of d, MSB first, and keeps the last eight bits seen on so.
    task automatic frame(input logic [63:0] d, input int n, output logic [7:0] rd);
        int i;
        rd = 8'h00;
        @(posedge clk_i) cs_b_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (i = n - 1; i >= 0; i--) begin
            si_o <= d[i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            rd = {rd[6:0], so_i};
            sclk_o <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        cs_b_o <= 1'b1;
        si_o <= ~si_o;
        repeat (8) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

/* File: test_serial_flash_status_protect.sv */
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_status_protect;
    logic clk_i, rst_b_i, wp_b_i, sclk, cs_b, si, so, so_oe, op_start, qe, lb;
    logic [15:0] sw, ex, w;
    logic [2:0] op_kind;
    logic [23:0] op_addr, a;
    logic [7:0] op_data, rd, dv;
    logic [31:0] seed;
    logic [7:0] ops [3] = '{8'h20, 8'h52, 8'hD8};
    int miscompares, n_tests, starts, j;
    sfsp_core #(.PROG_CYCLES(400), .ERASE_CYCLES(400), .SRW_CYCLES(40)) DUT (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .ce_i(1'b1), .sclk_i(sclk), .cs_b_i(cs_b), .si_i(si), .wp_b_i(wp_b_i), .so_o(so), .so_oe_o(so_oe),
        .status_word_o(sw), .op_start_o(op_start), .op_kind_o(op_kind), .op_addr_o(op_addr),
        .op_data_o(op_data), .quad_io_enable_o(qe), .security_lock_o(lb));
    sfsp_host host (.clk_i(clk_i), .so_i(so), .sclk_o(sclk), .cs_b_o(cs_b), .si_o(si));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (op_start === 1'b1) starts++;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmd(input logic [63:0] d, input int n);
        host.frame(d, n, rd);
    endtask
    // Waits out the busy time under a bound.
    task automatic idle;
        int i;
        for (i = 0; i < 3000 && sw[0] !== 1'b0; i++) @(posedge clk_i);
        if (sw[0] !== 1'b0) begin
            miscompares++;
            print_verdict;
        end
        repeat (4) @(posedge clk_i);
    endtask
    task automatic status_write_cmd(input logic [15:0] v);
        cmd(64'h06, 8);
        cmd({40'h0, 8'h01, v[7:0], v[15:8]}, 24);
        idle;
    endtask
    initial begin
        rst_b_i = 1'b0;
        wp_b_i = 1'b1;
        seed = 32'd53217;
        miscompares = 0;
        n_tests = 0;
        starts = 0;
        ex = 16'h0000;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check(sw, 16'h0000);
        cmd(64'h03, 7);
        check(sw, 16'h0000);
        cmd(64'h06, 8);
        check(sw, 16'h0002);
        cmd(64'h04, 8);
        cmd(64'h011C00, 24);
        check(sw, 16'h0000);
        for (j = 0; j < 6; j++) begin
            seed = xs(seed);
            w = seed[15:0] & 16'hFE7F;
            wp_b_i <= seed[16];
            cmd(64'h06, 8);
            cmd({40'h0, 8'h01, w[7:0], w[15:8]}, 24);
            check({14'h0, sw[1:0]}, 16'h0001);
            idle;
            ex = (w & 16'h467C) | (ex & 16'h0400);
            check(sw, ex);
            check({14'h0, lb, qe}, {14'h0, ex[10:9]});
            cmd(64'h0500, 16);
            check({8'h0, rd}, {8'h0, ex[7:0]});
            check({15'h0, so_oe}, 16'h0000);
            cmd(64'h3500, 16);
            check({8'h0, rd}, {8'h0, ex[15:8]});
        end
        wp_b_i <= 1'b1;
        status_write_cmd(16'h0000);
        ex = ex & 16'h0400;
        seed = xs(seed);
        a = seed[23:0] & 24'h0EFFFF;
        dv = seed[31:24];
        cmd(64'h06, 8);
        cmd({27'h0, 8'h02, a, dv[7:3]}, 37);
        check({15'h0, sw[1]}, 16'h0001);
        cmd({24'h0, 8'h02, a, dv}, 40);
        check(16'(starts), 16'h0001);
        check({13'h0, op_kind}, 16'h0001);
        check({op_addr[15:0]}, a[15:0]);
        check({8'h0, op_data}, {8'h0, dv});
        check({14'h0, sw[1:0]}, 16'h0001);
        cmd(64'h75, 8);
        check({14'h0, sw[15], sw[0]}, 16'h0002);
        cmd(64'h7A, 8);
        check({15'h0, sw[15]}, 16'h0000);
        idle;
        status_write_cmd(16'h0004);
        cmd(64'h06, 8);
        cmd(64'hC7, 8);
        cmd(64'h200FF000, 32);
        check(16'(starts), 16'h0001);
        status_write_cmd(16'h0000);
        for (j = 0; j < 4; j++) begin
            cmd(64'h06, 8);
            cmd(j < 3 ? {32'h0, ops[j], a} : 64'hC7, j < 3 ? 32 : 8);
            check({13'h0, op_kind}, 16'(j + 2));
            check(16'(starts), 16'(j + 2));
            idle;
        end
        status_write_cmd(16'h0080);
        wp_b_i <= 1'b0;
        status_write_cmd(16'h0004);
        check(sw, 16'h0082 | ex);
        wp_b_i <= 1'b1;
        status_write_cmd(16'h0100);
        status_write_cmd(16'h0004);
        check(sw, 16'h0102 | ex);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check(sw, 16'h0000);
        status_write_cmd(16'h0180);
        status_write_cmd(16'h0004);
        check(sw, 16'h0182);
        cmd(64'hA3000000, 32);
        check(sw, 16'h2182);
        cmd(64'hB9, 8);
        cmd(64'h04, 8);
        cmd(64'hAB, 8);
        check(sw, 16'h0182);
        print_verdict;
    end
endmodule
`default_nettype wire
